// ### src/crcu_pkg.sv
// constants, register map and types shared by both ends of the crc unit
package crcu_pkg;
   // ============
   // special function register map of the checksum unit
   localparam logic [7:0]  CTRL_OFS      = 8'hce; // checksum_control_reg
   localparam logic [7:0]  INPUT_OFS     = 8'hdd; // checksum_input_reg
   localparam logic [7:0]  DATA_OFS      = 8'hde; // result_data_reg
   localparam logic [7:0]  AUTO_OFS      = 8'hd2; // auto_flash_config_reg
   localparam logic [7:0]  COUNT_OFS     = 8'hd3; // block_count_reg
   localparam logic [7:0]  FLIP_OFS      = 8'hcf; // bit_reverse_reg
   // ============
   // control register fields and reset values
   localparam int          CTRL_INIT_BIT = 3;     // result_init_strobe
   localparam int          CTRL_VAL_BIT  = 2;     // init_value_select
   localparam int          CTRL_PTR_BIT  = 0;     // result_byte_pointer
   localparam logic [3:0]  CTRL_RSVD_HI  = 4'h1;  // bits 7:4 reset value
   localparam logic [7:0]  CTRL_RESET    = 8'h10;
   localparam int          AUTO_EN_BIT   = 7;     // auto_flash_enable
   localparam int          PAGE_W        = 6;     // start page field 5:0
   // ============
   // arithmetic constants
   localparam logic [15:0] CRC_POLY      = 16'h1021;
   localparam logic [15:0] CRC_INIT_LO   = 16'h0000;
   localparam logic [15:0] CRC_INIT_HI   = 16'hffff;
   localparam logic [7:0]  PAGE_LOW_ADDR = 8'h00; // 256-byte blocks
   localparam logic [2:0]  START_GAP     = 3'h3;  // cycles after a start
   // ============
   // controller registers on the axi4-lite side
   localparam logic [7:0]  AXI_CMD_OFS   = 8'h00;
   localparam logic [7:0]  AXI_STAT_OFS  = 8'h04;
   localparam int          CMD_RD_BIT    = 16;
   localparam logic [1:0]  RESP_OKAY     = 2'b00;
   localparam logic [1:0]  RESP_SLVERR   = 2'b10;
   // ============
   // controller sequencer states
   typedef enum logic [3:0] {
      H_IDLE  = 4'b0001,
      H_ACC   = 4'b0010,
      H_RWAIT = 4'b0100,
      H_GAP   = 4'b1000
   } crcu_hstate_t;
endpackage : crcu_pkg

// ### src/crcu_if.sv
// interface joining the crc unit and its processor-side controller
`timescale 1ns/1ps
interface crcu_if;
   logic [7:0]  sfr_addr;    // register address
   logic [7:0]  sfr_wdata;   // write data
   logic        sfr_wr;      // one-cycle write strobe
   logic        sfr_rd;      // one-cycle read strobe
   logic [7:0]  sfr_rdata;   // read data, valid the cycle after sfr_rd
   logic        cpu_stall;   // high while an automatic run is busy
   logic        flash_req;   // level, held until the last flash_ack of a run
   logic [15:0] flash_addr;  // byte address of the request
   logic        flash_ack;   // one-cycle pulse with flash_data
   logic [7:0]  flash_data;  // flash byte
   // ============
   modport dev (
      input  sfr_addr, sfr_wdata, sfr_wr, sfr_rd, flash_ack, flash_data,
      output sfr_rdata, cpu_stall, flash_req, flash_addr
   );
   modport host (
      output sfr_addr, sfr_wdata, sfr_wr, sfr_rd, flash_ack, flash_data,
      input  sfr_rdata, cpu_stall, flash_req, flash_addr
   );
endinterface : crcu_if

// ### src/crcu_unit.sv
// crc-16 checksum unit with byte bit reversal and automatic flash mode
`timescale 1ns/1ps
module crcu_unit (
   input  wire logic clock,
   input  wire logic nrst,
   crcu_if.dev       bus
);

   // ============
   // state
   // every flop of the unit sits in this one struct
   typedef struct packed {
      logic [15:0]                  result;    // running crc value
      logic                         ptr;       // result_byte_pointer
      logic                         init_val;  // init_value_select
      logic                         auto_en;   // auto_flash_enable
      logic [crcu_pkg::PAGE_W-1:0]  page;      // start page index
      logic [7:0]                   blk_cnt;   // block_count_reg
      logic [7:0]                   flip;      // bit_reverse_reg
      logic [7:0]                   rdata;     // registered read data
      logic                         busy;      // automatic run active
      logic                         freq;      // flash request level
      logic [15:0]                  faddr;     // next flash byte
      logic [15:0]                  left;      // bytes still to fold
   } crcu_dstate_t;

   crcu_dstate_t st_reg;   // registered state
   crcu_dstate_t st_next;  // next state

   // ============
   // per-byte crc step
   // one byte per call; a single cycle covers the whole byte, which
   // costs eight xor stages of depth but keeps the result current
   function automatic logic [15:0] crc_byte(
      input logic [15:0] crc,
      input logic [7:0]  din
   );
      logic [15:0] c;
      c = crc ^ {din, 8'h00};
      for (int i = 0; i < 8; i++) begin
         if (c[15]) begin
            c = {c[14:0], 1'b0} ^ crcu_pkg::CRC_POLY;
         end else begin
            c = {c[14:0], 1'b0};
         end
      end
      return c;
   endfunction : crc_byte

   // mirror the bit order of one byte
   function automatic logic [7:0] bit_mirror(
      input logic [7:0] b
   );
      logic [7:0] m;
      m = 8'h00;
      for (int i = 0; i < 8; i++) begin
         m[i] = b[7-i];
      end
      return m;
   endfunction : bit_mirror

   // ============
   // next-state logic
   // the bus is not looked at while busy: the stalled core cannot
   // issue accesses, so nothing competes with the flash feed
   always_comb begin
      st_next = st_reg;
      if (st_reg.busy) begin
         // automatic run: one flash byte per acknowledge
         // a started run cannot be aborted
         if (bus.flash_ack) begin
            st_next.result = crc_byte(st_reg.result, bus.flash_data);
            st_next.faddr  = st_reg.faddr + 16'h0001;
            st_next.left   = st_reg.left - 16'h0001;
            if (st_reg.left == 16'h0001) begin
               // last byte of the last block: release the core
               st_next.busy = 1'b0;
               st_next.freq = 1'b0;
            end
         end
      end else if (bus.sfr_wr) begin
         // register writes
         unique case (bus.sfr_addr)
            crcu_pkg::CTRL_OFS: begin
               // reserved bits are ignored on write
               st_next.init_val = bus.sfr_wdata[crcu_pkg::CTRL_VAL_BIT];
               st_next.ptr      = bus.sfr_wdata[crcu_pkg::CTRL_PTR_BIT];
               if (bus.sfr_wdata[crcu_pkg::CTRL_INIT_BIT]) begin
                  // select bit of the same write is used
                  st_next.result =
                     bus.sfr_wdata[crcu_pkg::CTRL_VAL_BIT] ?
                     crcu_pkg::CRC_INIT_HI : crcu_pkg::CRC_INIT_LO;
               end
               // any control write starts a run when auto is on;
               // a zero block count starts nothing
               if (st_reg.auto_en && (st_reg.blk_cnt != 8'h00)) begin
                  // page plus count may wrap past 64k
                  st_next.busy  = 1'b1;
                  st_next.freq  = 1'b1;
                  st_next.faddr = {{(8-crcu_pkg::PAGE_W){1'b0}},
                                   st_reg.page,
                                   crcu_pkg::PAGE_LOW_ADDR};
                  st_next.left  = {st_reg.blk_cnt,
                                   crcu_pkg::PAGE_LOW_ADDR};
               end
            end
            crcu_pkg::INPUT_OFS: begin
               // fold the byte, visible on the next cycle
               st_next.result = crc_byte(st_reg.result,
                                         bus.sfr_wdata);
            end
            crcu_pkg::DATA_OFS: begin
               // overwrite one result byte, then toggle
               if (st_reg.ptr) begin
                  st_next.result[15:8] = bus.sfr_wdata;
               end else begin
                  st_next.result[7:0]  = bus.sfr_wdata;
               end
               st_next.ptr = ~st_reg.ptr;
            end
            crcu_pkg::AUTO_OFS: begin
               st_next.auto_en = bus.sfr_wdata[crcu_pkg::AUTO_EN_BIT];
               st_next.page    = bus.sfr_wdata[crcu_pkg::PAGE_W-1:0];
            end
            crcu_pkg::COUNT_OFS: begin
               st_next.blk_cnt = bus.sfr_wdata;
            end
            crcu_pkg::FLIP_OFS: begin
               st_next.flip = bus.sfr_wdata;
            end
            default: begin
               // other addresses belong to other blocks
            end
         endcase
      end else if (bus.sfr_rd) begin
         // register reads, answered on the next cycle
         // reads while busy are dropped too
         unique case (bus.sfr_addr)
            crcu_pkg::CTRL_OFS: begin
               // init strobe reads back as zero
               st_next.rdata = {crcu_pkg::CTRL_RSVD_HI, 1'b0,
                                st_reg.init_val, 1'b0, st_reg.ptr};
            end
            crcu_pkg::DATA_OFS: begin
               st_next.rdata = st_reg.ptr ? st_reg.result[15:8]
                                          : st_reg.result[7:0];
               // a read moves the pointer too
               st_next.ptr   = ~st_reg.ptr;
            end
            crcu_pkg::AUTO_OFS: begin
               st_next.rdata = {st_reg.auto_en,
                                {(7-crcu_pkg::PAGE_W){1'b0}},
                                st_reg.page};
            end
            crcu_pkg::COUNT_OFS: begin
               st_next.rdata = st_reg.blk_cnt;
            end
            crcu_pkg::FLIP_OFS: begin
               st_next.rdata = bit_mirror(st_reg.flip);
            end
            default: begin
               // input register is write-only, others read zero
               st_next.rdata = 8'h00;
            end
         endcase
      end
      // with no access the result simply holds
   end

   // ============
   // state register
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         // fixed control bits are read constants
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ============
   // outputs, all straight from the state register
   // read data holds until the next read
   assign bus.sfr_rdata  = st_reg.rdata;
   assign bus.cpu_stall  = st_reg.busy;
   assign bus.flash_req  = st_reg.freq;
   assign bus.flash_addr = st_reg.faddr;

endmodule : crcu_unit

// ### src/crcu_host.sv
// processor-side controller: axi4-lite orders to special register accesses
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
module crcu_host (
   input  wire logic        clock,
   input  wire logic        nrst,
   crcu_if.host             bus,
   // axi4-lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // flash byte source
   output logic             flash_rd_en,
   output logic [15:0]      flash_rd_addr,
   input  wire logic [7:0]  flash_rd_data,
   input  wire logic        flash_rd_valid
);

   // ============
   // state
   typedef struct packed {
      crcu_pkg::crcu_hstate_t st;      // sequencer state
      logic                   aw_got;  // write address held
      logic                   w_got;   // write data held
      logic [7:0]             awaddr;  // held write address
      logic [31:0]            wdata;   // held write data
      logic                   bvalid;
      logic [1:0]             bresp;
      logic                   rvalid;
      logic [1:0]             rresp;
      logic [31:0]            rdata;
      logic [16:0]            cmd;     // last command word
      logic                   sfr_wr;
      logic                   sfr_rd;
      logic [2:0]             gap;     // quiet cycles after a start
      logic [7:0]             last_rd; // last register read data
      logic                   fl_wait; // flash read outstanding
      logic                   fl_en;
      logic [15:0]            fl_addr;
      logic                   ack;
      logic [7:0]             fdata;
   } crcu_hst_t;

   crcu_hst_t h_reg;   // registered state
   crcu_hst_t h_next;  // next state

   // ============
   // next-state logic
   always_comb begin
      h_next        = h_reg;
      h_next.sfr_wr = 1'b0;
      h_next.sfr_rd = 1'b0;
      h_next.ack    = 1'b0;
      h_next.fl_en  = 1'b0;
      // write channels, taken in either order
      if (s_axi_awvalid && !h_reg.aw_got) begin
         h_next.aw_got = 1'b1;
         h_next.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !h_reg.w_got) begin
         h_next.w_got = 1'b1;
         h_next.wdata = s_axi_wdata;
      end
      if (h_reg.bvalid && s_axi_bready) begin
         h_next.bvalid = 1'b0;
         h_next.aw_got = 1'b0;
         h_next.w_got  = 1'b0;
      end
      // sequencer
      unique case (h_reg.st)
         crcu_pkg::H_IDLE: begin
            // a stalled core issues nothing
            if (h_reg.aw_got && h_reg.w_got && !h_reg.bvalid &&
                !bus.cpu_stall) begin
               h_next.bvalid = 1'b1;
               if (h_reg.awaddr == crcu_pkg::AXI_CMD_OFS) begin
                  h_next.bresp  = crcu_pkg::RESP_OKAY;
                  h_next.cmd    = h_reg.wdata[16:0];
                  h_next.sfr_rd = h_reg.wdata[crcu_pkg::CMD_RD_BIT];
                  h_next.sfr_wr = ~h_reg.wdata[crcu_pkg::CMD_RD_BIT];
                  h_next.st     = crcu_pkg::H_ACC;
                  if (h_reg.wdata[15:8] == crcu_pkg::CTRL_OFS) begin
                     // reserved bits forced to reset value
                     h_next.cmd[7:4] = crcu_pkg::CTRL_RESET[7:4];
                     h_next.cmd[1]   = crcu_pkg::CTRL_RESET[1];
                  end
               end else begin
                  h_next.bresp = crcu_pkg::RESP_SLVERR;
               end
            end
         end
         crcu_pkg::H_ACC: begin
            if (h_reg.sfr_rd) begin
               h_next.st = crcu_pkg::H_RWAIT;
            end else if (h_reg.cmd[15:8] == crcu_pkg::CTRL_OFS) begin
               // simple steps only right after a start
               h_next.st  = crcu_pkg::H_GAP;
               h_next.gap = crcu_pkg::START_GAP;
            end else begin
               h_next.st = crcu_pkg::H_IDLE;
            end
         end
         crcu_pkg::H_RWAIT: begin
            h_next.last_rd = bus.sfr_rdata;
            h_next.st      = crcu_pkg::H_IDLE;
         end
         crcu_pkg::H_GAP: begin
            h_next.gap = h_reg.gap - 3'h1;
            if (h_reg.gap == 3'h1) begin
               h_next.st = crcu_pkg::H_IDLE;
            end
         end
      endcase
      // read channel, one word per request
      if (h_reg.rvalid && s_axi_rready) begin
         h_next.rvalid = 1'b0;
      end else if (s_axi_arvalid && !h_reg.rvalid) begin
         h_next.rvalid = 1'b1;
         h_next.rresp  = crcu_pkg::RESP_OKAY;
         if (s_axi_araddr == crcu_pkg::AXI_CMD_OFS) begin
            h_next.rdata = {15'h0000, h_reg.cmd};
         end else if (s_axi_araddr == crcu_pkg::AXI_STAT_OFS) begin
            // result is read back via last_rd after a run
            h_next.rdata = {16'h0000, h_reg.last_rd, 6'h00,
                            bus.cpu_stall,
                            (h_reg.st != crcu_pkg::H_IDLE)};
         end else begin
            h_next.rdata = 32'h0000_0000;
            h_next.rresp = crcu_pkg::RESP_SLVERR;
         end
      end
      // flash feed: one byte in flight, skip the ack cycle
      if (!h_reg.fl_wait && !h_reg.ack && bus.flash_req) begin
         h_next.fl_en   = 1'b1;
         h_next.fl_addr = bus.flash_addr;
         h_next.fl_wait = 1'b1;
      end
      if (h_reg.fl_wait && flash_rd_valid) begin
         h_next.fl_wait = 1'b0;
         h_next.ack     = 1'b1;
         h_next.fdata   = flash_rd_data;
      end
   end

   // ============
   // state register
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         h_reg    <= '0;
         h_reg.st <= crcu_pkg::H_IDLE;
      end else begin
         h_reg <= h_next;
      end
   end

   // ============
   // outputs from flops
   assign s_axi_awready  = ~h_reg.aw_got;
   assign s_axi_wready   = ~h_reg.w_got;
   assign s_axi_bvalid   = h_reg.bvalid;
   assign s_axi_bresp    = h_reg.bresp;
   assign s_axi_arready  = ~h_reg.rvalid;
   assign s_axi_rvalid   = h_reg.rvalid;
   assign s_axi_rresp    = h_reg.rresp;
   assign s_axi_rdata    = h_reg.rdata;
   assign bus.sfr_addr   = h_reg.cmd[15:8];
   assign bus.sfr_wdata  = h_reg.cmd[7:0];
   assign bus.sfr_wr     = h_reg.sfr_wr;
   assign bus.sfr_rd     = h_reg.sfr_rd;
   assign bus.flash_ack  = h_reg.ack;
   assign bus.flash_data = h_reg.fdata;
   assign flash_rd_en    = h_reg.fl_en;
   assign flash_rd_addr  = h_reg.fl_addr;

endmodule : crcu_host

// ### verif/crcu_asserts.sv
// concurrent checks on the link between the crc unit and its controller
`timescale 1ns/1ps
module crcu_asserts (
   input wire logic        clock,
   input wire logic        nrst,
   input wire logic [7:0]  sfr_addr,
   input wire logic [7:0]  sfr_wdata,
   input wire logic        sfr_wr,
   input wire logic        sfr_rd,
   input wire logic [7:0]  sfr_rdata,
   input wire logic        cpu_stall,
   input wire logic        flash_req,
   input wire logic [15:0] flash_addr,
   input wire logic        flash_ack,
   input wire logic [7:0]  flash_data
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   // ============
   // shadow of the configuration, kept only from accepted writes
   logic [7:0]  flip_q, auto_q, cnt_q; // last accepted values
   logic [16:0] ack_n;                 // bytes fed during this run
   wire         wr_ok = sfr_wr && !cpu_stall; // stalled writes are lost
   wire         rd_ok = sfr_rd && !cpu_stall;
   wire         start = wr_ok && sfr_addr == crcu_pkg::CTRL_OFS &&
                auto_q[crcu_pkg::AUTO_EN_BIT] && cnt_q != 8'h00;
   wire [7:0]   flip_rev = {<<{flip_q}};   // mirrored byte
   // shadow registers and byte counter
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         flip_q <= 8'h00;
         auto_q <= 8'h00;
         cnt_q  <= 8'h00;
         ack_n  <= '0;
      end else begin
         if (wr_ok && sfr_addr == crcu_pkg::FLIP_OFS) flip_q <= sfr_wdata;
         if (wr_ok && sfr_addr == crcu_pkg::AUTO_OFS) auto_q <= sfr_wdata;
         if (wr_ok && sfr_addr == crcu_pkg::COUNT_OFS) cnt_q <= sfr_wdata;
         if (start) ack_n <= '0;
         else if (flash_ack) ack_n <= ack_n + 17'h1;
      end
   end
   // ============
   // properties
   sequence s_quiet; (!sfr_wr && !sfr_rd) [*3]; endsequence
   sequence s_run_up;
      cpu_stall && flash_req &&
      flash_addr == {2'b00, auto_q[5:0], crcu_pkg::PAGE_LOW_ADDR};
   endsequence
   property p_start; start |=> s_run_up; endproperty
   property p_gap; start |=> s_quiet; endproperty
   property p_flip;
      rd_ok && sfr_addr == crcu_pkg::FLIP_OFS |=> sfr_rdata == flip_rev;
   endproperty
   property p_step;
      flash_ack |=> !flash_req || flash_addr == $past(flash_addr) + 16'h1;
   endproperty
   property p_count;
      $fell(cpu_stall) |-> ack_n == {1'b0, cnt_q, 8'h00} && !flash_req;
   endproperty
   property p_req_stall; flash_req |-> cpu_stall; endproperty
   property p_ack_pulse; flash_ack |=> !flash_ack; endproperty
   property p_rd_hold; !sfr_rd |=> $stable(sfr_rdata); endproperty
   property p_ctrl_rd;
      rd_ok && sfr_addr == crcu_pkg::CTRL_OFS |=>
      sfr_rdata[7:4] == crcu_pkg::CTRL_RSVD_HI && !sfr_rdata[3] &&
      !sfr_rdata[1];
   endproperty
   a_start: assert property (p_start)
      else $error("run start wrong");
   a_gap: assert property (p_gap)
      else $error("access in start gap");
   a_flip: assert property (p_flip)
      else $error("bit reverse read wrong");
   a_step: assert property (p_step)
      else $error("flash address step wrong");
   a_count: assert property (p_count)
      else $error("run byte count wrong");
   a_req_stall: assert property (p_req_stall)
      else $error("flash request without stall");
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("flash ack too long");
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data changed");
   a_ctrl_rd: assert property (p_ctrl_rd)
      else $error("control fixed bits wrong");
endmodule : crcu_asserts

// ### verif/tb.sv
// self-checking bench: controller and crc unit joined back to back
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
   $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb;
   logic             clock, nrst;       // system clock, reset
   logic [7:0]       awaddr, araddr;    // axi addresses
   logic             awvalid, wvalid, bready, arvalid, rready;
   logic [31:0]      wdata;             // axi write word
   wire logic        awready, wready, bvalid, arready, rvalid, f_en;
   wire logic [1:0]  bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [15:0] f_addr;            // flash byte address
   logic [7:0]       f_data;            // flash model output
   logic             f_valid;
   int               n_mismatch, tests_run;
   logic [15:0]      crc;               // expected result
   crcu_if bus ();
   crcu_unit i_crcu_unit (.clock, .nrst, .bus);
   crcu_host i_crcu_host (.clock, .nrst, .bus,
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .flash_rd_en(f_en),
      .flash_rd_addr(f_addr), .flash_rd_data(f_data),
      .flash_rd_valid(f_valid));
   crcu_asserts i_crcu_asserts (.clock, .nrst,
      .sfr_addr(bus.sfr_addr), .sfr_wdata(bus.sfr_wdata),
      .sfr_wr(bus.sfr_wr), .sfr_rd(bus.sfr_rd), .sfr_rdata(bus.sfr_rdata),
      .cpu_stall(bus.cpu_stall), .flash_req(bus.flash_req),
      .flash_addr(bus.flash_addr), .flash_ack(bus.flash_ack),
      .flash_data(bus.flash_data));
   // ============
   // clock and flash model: byte comes the cycle after the request
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   function automatic logic [7:0] fbyte(logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5c;
   endfunction : fbyte
   always @(posedge clock) begin
      f_valid <= f_en;
      f_data  <= fbyte(f_addr);
   end
   // reference update, one byte msb first
   function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] b);
      logic [15:0] r;
      r = c ^ {b, 8'h00};
      for (int i = 0; i < 8; i++) begin
         r = r[15] ? {r[14:0], 1'b0} ^ crcu_pkg::CRC_POLY : {r[14:0], 1'b0};
      end
      return r;
   endfunction : crc_step
   // ============
   // verdict and bus tasks
   task automatic summarize;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : summarize
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         output logic [1:0] r);
      int i;
      @(posedge clock);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (i = 0; i < 5000; i++) begin
         @(posedge clock);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      r = bresp;
      bready <= 1'b0;
      if (i == 5000) begin n_mismatch++; summarize(); end
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      int i;
      @(posedge clock);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (i = 0; i < 5000; i++) begin
         @(posedge clock);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      if (i == 5000) begin n_mismatch++; summarize(); end
   endtask : axi_rd
   // register access through the command word
   task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
      logic [1:0] r;
      axi_wr(crcu_pkg::AXI_CMD_OFS, {16'h0000, a, d}, r);
      `CHK(r, crcu_pkg::RESP_OKAY)
   endtask : sfr_w
   task automatic sfr_r(input logic [7:0] a, output logic [7:0] d);
      logic [1:0]  r;
      logic [31:0] v;
      axi_wr(crcu_pkg::AXI_CMD_OFS, {16'h0001, a, 8'h00}, r);
      repeat (3) @(posedge clock);   // status latches two cycles on
      axi_rd(crcu_pkg::AXI_STAT_OFS, v, r);
      d = v[15:8];
   endtask : sfr_r
   task automatic rd_result;   // pointer must be at the low byte
      logic [7:0] d;
      sfr_r(crcu_pkg::DATA_OFS, d);
      `CHK(d, crc[7:0])
      sfr_r(crcu_pkg::DATA_OFS, d);
      `CHK(d, crc[15:8])
   endtask : rd_result
   // ============
   // scenarios
   task automatic t_refuse;   // reset value, unmapped axi places
      logic [7:0]  d;
      logic [31:0] v;
      logic [1:0]  r;
      sfr_r(crcu_pkg::CTRL_OFS, d);
      `CHK(d, crcu_pkg::CTRL_RESET)
      axi_rd(crcu_pkg::AXI_CMD_OFS, v, r);
      `CHK(v, {16'h0001, crcu_pkg::CTRL_OFS, crcu_pkg::CTRL_RESET})
      axi_wr(8'h08, 32'h0000_00ff, r);
      `CHK(r, crcu_pkg::RESP_SLVERR)
      axi_rd(8'h0c, v, r);
      `CHK(r, crcu_pkg::RESP_SLVERR)
      `CHK(v, 32'h0000_0000)
   endtask : t_refuse
   task automatic t_manual;   // both init values, then three bytes
      for (int v = 0; v < 2; v++) begin
         sfr_w(crcu_pkg::CTRL_OFS, 8'h18 | (v[0] ? 8'h04 : 8'h00));
         crc = v[0] ? crcu_pkg::CRC_INIT_HI : crcu_pkg::CRC_INIT_LO;
         rd_result();
         for (int i = 0; i < 3; i++) begin
            sfr_w(crcu_pkg::INPUT_OFS, 8'h31 + 8'(i));
            crc = crc_step(crc, 8'h31 + 8'(i));
         end
         rd_result();
      end
   endtask : t_manual
   task automatic t_data_flip;   // one byte written, mirrored reads
      logic [7:0] d;
      logic [7:0] tin [3] = '{8'hc0, 8'h01, 8'h96};
      logic [7:0] tout [3] = '{8'h03, 8'h80, 8'h69};
      sfr_w(crcu_pkg::DATA_OFS, 8'h5a);
      crc[7:0] = 8'h5a;
      sfr_r(crcu_pkg::DATA_OFS, d);
      `CHK(d, crc[15:8])
      sfr_r(crcu_pkg::DATA_OFS, d);
      `CHK(d, crc[7:0])
      for (int i = 0; i < 3; i++) begin
         sfr_w(crcu_pkg::FLIP_OFS, tin[i]);
         sfr_r(crcu_pkg::FLIP_OFS, d);
         `CHK(d, tout[i])
      end
      sfr_w(crcu_pkg::CTRL_OFS, crcu_pkg::CTRL_RESET); // pointer to low
      rd_result();
   endtask : t_data_flip
   task automatic t_auto;   // two blocks from page 2, cpu stalled
      logic [31:0] v;
      logic [1:0]  r;
      logic        seen;
      int          i;
      seen = 1'b0;
      sfr_w(crcu_pkg::CTRL_OFS, 8'h1c);
      crc = crcu_pkg::CRC_INIT_HI;
      sfr_w(crcu_pkg::AUTO_OFS, 8'h82);
      sfr_w(crcu_pkg::COUNT_OFS, 8'h02);
      sfr_w(crcu_pkg::CTRL_OFS, crcu_pkg::CTRL_RESET);
      for (i = 0; i < 1000; i++) begin
         axi_rd(crcu_pkg::AXI_STAT_OFS, v, r);
         if (v[1]) seen = 1'b1;
         if (v[1:0] == 2'b00) break;
      end
      if (i == 1000) begin n_mismatch++; summarize(); end
      `CHK(seen, 1'b1)
      sfr_w(crcu_pkg::AUTO_OFS, 8'h00);
      for (int a = 16'h0200; a < 16'h0400; a++) begin
         crc = crc_step(crc, fbyte(16'(a)));
      end
      rd_result();
   endtask : t_auto
   // main sequence
   initial begin
      n_mismatch = 0;
      tests_run  = 0;
      nrst       = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata} = 48'h0;
      repeat (5) @(posedge clock);
      nrst <= 1'b1;
      t_refuse();
      t_manual();
      t_data_flip();
      t_auto();
      summarize();
   end
endmodule : tb
